/* src/demod_cfg_pkg.sv */
// Purpose: Shared constants for the demodulator configuration register bank
// Assumes: Six 16-bit registers at byte offsets 0x21..0x32 of the serial map
// Notes:   Masks list the bits that software may change in each register
package demod_cfg_pkg;

  localparam int unsigned DATA_W = 16;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned NUM_REGS = 6;
  localparam int unsigned IDX_W = 3;

  // Register offsets
  localparam logic [7:0] PHASE_DETECTOR_CONTROL_ADDR = 8'h21;
  localparam logic [7:0] OSCILLATOR_PATH_CONTROL_ADDR = 8'h22;
  localparam logic [7:0] RF_INPUT_GAIN_CONTROL_ADDR = 8'h23;
  localparam logic [7:0] INPUT_TRANSFORMER_TUNING_ADDR = 8'h30;
  localparam logic [7:0] MIXER_LINEARITY_CONTROL_ADDR = 8'h31;
  localparam logic [7:0] QUADRATURE_POLARITY_NULLING_ADDR = 8'h32;

  // Storage indexes
  localparam logic [2:0] IDX_PD = 3'h0;
  localparam logic [2:0] IDX_OSC = 3'h1;
  localparam logic [2:0] IDX_RF = 3'h2;
  localparam logic [2:0] IDX_BAL = 3'h3;
  localparam logic [2:0] IDX_MIX = 3'h4;
  localparam logic [2:0] IDX_POL = 3'h5;

  // Reset values
  localparam logic [15:0] PHASE_DETECTOR_CONTROL_RST = 16'h0003;
  localparam logic [15:0] OSCILLATOR_PATH_CONTROL_RST = 16'h2a03;
  localparam logic [15:0] RF_INPUT_GAIN_CONTROL_RST = 16'h0000;
  localparam logic [15:0] INPUT_TRANSFORMER_TUNING_RST = 16'h0000;
  localparam logic [15:0] MIXER_LINEARITY_CONTROL_RST = 16'h1101;
  localparam logic [15:0] QUADRATURE_POLARITY_NULLING_RST = 16'h0900;

  // Writable bit masks
  localparam logic [15:0] PHASE_DETECTOR_CONTROL_MASK = 16'h007f;
  localparam logic [15:0] OSCILLATOR_PATH_CONTROL_MASK = 16'h00ff;
  localparam logic [15:0] RF_INPUT_GAIN_CONTROL_MASK = 16'h0be0;
  localparam logic [15:0] INPUT_TRANSFORMER_TUNING_MASK = 16'h00ee;
  localparam logic [15:0] MIXER_LINEARITY_CONTROL_MASK = 16'h1def;
  localparam logic [15:0] QUADRATURE_POLARITY_NULLING_MASK = 16'h0fff;

  // Field positions (low bit)
  localparam int unsigned MON_SEL_LSB = 4;
  localparam int unsigned PD_SENSE_BIT = 3;
  localparam int unsigned REF_RATIO_LSB = 0;
  localparam int unsigned DRV_LVL_LSB = 6;
  localparam int unsigned DRV_HALF_BIT = 5;
  localparam int unsigned DIV8_BIT = 4;
  localparam int unsigned DIV4_BIT = 3;
  localparam int unsigned CORE_SEL_LSB = 0;
  localparam int unsigned SW_SRC_BIT = 11;
  localparam int unsigned SW_SEL_BIT = 9;
  localparam int unsigned ATTEN_LSB = 5;
  localparam int unsigned BAL_OUT_LSB = 5;
  localparam int unsigned BAL_IN_LSB = 1;
  localparam int unsigned BIAS_LSB = 10;
  localparam int unsigned RES_LSB = 5;
  localparam int unsigned CAP_LSB = 0;
  localparam int unsigned Q_POLARITY_SWITCH_LSB = 10;
  localparam int unsigned I_POLARITY_SWITCH_LSB = 8;
  localparam int unsigned QNULL_LSB = 4;
  localparam int unsigned INULL_LSB = 0;

  // Codes
  localparam logic [2:0] REF_MUL2 = 3'h0;
  localparam logic [2:0] REF_DIV8 = 3'h4;
  localparam logic [2:0] CORE_EXTERNAL = 3'h4;
  localparam logic [1:0] POL_NORMAL_Q = 2'h2;
  localparam logic [1:0] POL_INVERT_Q = 2'h1;
  localparam logic [1:0] POL_NORMAL_I = 2'h1;
  localparam logic [1:0] POL_INVERT_I = 2'h2;
  localparam logic [3:0] LO_DIV_BASE = 4'h2;
  localparam logic [3:0] LO_DIV_QUARTER = 4'h4;
  localparam logic [3:0] LO_DIV_EIGHTH = 4'h8;

endpackage : demod_cfg_pkg

/* src/demod_config_register_bank.sv */
// Purpose: Configuration register bank of the quadrature demodulator
// Assumes: Serial interface decoder delivers word writes/reads on clk_i
// Notes:   switch_control_pin_i is a pin and is synchronised before use
//
// Notes on behaviour
// - Six 16-bit registers at 0x21,0x22,0x23,0x30,0x31,0x32 with documented resets.
// - Bits 6:4 pick the monitored reference signal; bit 3 sets detector sense.
// - Bits 2:0 set reference ratio: x2, x1, /2, /4, /8.
// - Oscillator bit 5 halves external driver; bits 7:6 set external drive level.
// - Oscillator bit 4 adds a halving stage for a total LO divide of 8.
// - Oscillator bit 3 adds a halving stage for a total LO divide of 4.
// - Oscillator bits 2:0 pick one of four cores or the external LO.
// - Input switch follows the pin when bit 11 is 0, else register bit 9.
// - Bits 8:5 give binary step attenuation from 0 dB to 15 dB.
// - Transformer output cap at bits 7:5, input cap at 3:1, 000 minimum.
// - Demodulator bias code held at mixer bits 12:10, reset 4.
// - Linearizer resistor code at bits 8:5, capacitor code at bits 3:0.
// - Q polarity field 11:10: code 10 normal, code 01 inverted.
// - I polarity field 9:8: code 01 normal, code 10 inverted.
// - Q sideband nulling code held at polarity register bits 7:4.
// - I sideband nulling code held at polarity register bits 3:0.

`timescale 1ns/1ps
`default_nettype none

module demod_config_register_bank #(
  parameter int unsigned DATA_W = demod_cfg_pkg::DATA_W,
  parameter int unsigned ADDR_W = demod_cfg_pkg::ADDR_W
) (
  input  wire logic              clk_i,
  input  wire logic              rst_b_i,
  // Word access from the serial interface decoder
  input  wire logic              reg_wr_i,
  input  wire logic              reg_rd_i,
  input  wire logic [ADDR_W-1:0] reg_addr_i,
  input  wire logic [DATA_W-1:0] reg_wdata_i,
  output logic      [DATA_W-1:0] reg_rdata_o,
  output logic                   reg_rvalid_o,
  output logic                   reg_addr_err_o,
  // Pin that may steer the input switch
  input  wire logic              switch_control_pin_i,
  // Reference path
  output logic      [2:0]        monitor_select_o,
  output logic                   phase_detector_sense_o,
  output logic      [2:0]        reference_scaling_ratio_o,
  output logic                   ref_multiply_o,
  output logic      [1:0]        ref_divide_log2_o,
  output logic                   ref_ratio_invalid_o,
  // Oscillator and LO path
  output logic      [1:0]        ext_osc_drive_level_o,
  output logic                   ext_driver_halving_enable_o,
  output logic                   lo_eighth_divide_enable_o,
  output logic                   lo_quarter_divide_enable_o,
  output logic      [3:0]        lo_divide_total_o,
  output logic      [2:0]        oscillator_core_select_o,
  output logic      [3:0]        core_enable_onehot_o,
  output logic                   external_lo_select_o,
  output logic                   core_select_invalid_o,
  // RF input
  output logic                   input_switch_source_o,
  output logic                   input_switch_select_o,
  output logic      [3:0]        step_attenuation_setting_o,
  output logic      [3:0]        transformer_output_cap_o,
  output logic      [3:0]        transformer_input_cap_o,
  // Mixer
  output logic      [2:0]        demod_bias_code_o,
  output logic      [3:0]        linearizer_resistor_code_o,
  output logic      [3:0]        linearizer_capacitor_code_o,
  // Quadrature polarity and nulling
  output logic      [1:0]        q_polarity_switch_o,
  output logic      [1:0]        i_polarity_switch_o,
  output logic                   q_invert_o,
  output logic                   i_invert_o,
  output logic                   polarity_code_invalid_o,
  output logic      [3:0]        q_sideband_null_o,
  output logic      [3:0]        i_sideband_null_o
);

  localparam int unsigned NUM_REGS = demod_cfg_pkg::NUM_REGS;
  localparam int unsigned IDX_W = demod_cfg_pkg::IDX_W;

  // Address to storage index; hit is low for unmapped offsets
  function automatic logic [IDX_W:0] decode_addr(input logic [ADDR_W-1:0] addr);
    logic [IDX_W:0] res;
    res = '0;
    case (addr[7:0])
      demod_cfg_pkg::PHASE_DETECTOR_CONTROL_ADDR:      res = {1'b1, demod_cfg_pkg::IDX_PD};
      demod_cfg_pkg::OSCILLATOR_PATH_CONTROL_ADDR:     res = {1'b1, demod_cfg_pkg::IDX_OSC};
      demod_cfg_pkg::RF_INPUT_GAIN_CONTROL_ADDR:       res = {1'b1, demod_cfg_pkg::IDX_RF};
      demod_cfg_pkg::INPUT_TRANSFORMER_TUNING_ADDR:    res = {1'b1, demod_cfg_pkg::IDX_BAL};
      demod_cfg_pkg::MIXER_LINEARITY_CONTROL_ADDR:     res = {1'b1, demod_cfg_pkg::IDX_MIX};
      demod_cfg_pkg::QUADRATURE_POLARITY_NULLING_ADDR: res = {1'b1, demod_cfg_pkg::IDX_POL};
      default:                                         res = '0;
    endcase
    return res;
  endfunction

  function automatic logic [15:0] reset_value(input logic [IDX_W-1:0] idx);
    logic [15:0] res;
    res = '0;
    case (idx)
      demod_cfg_pkg::IDX_PD:  res = demod_cfg_pkg::PHASE_DETECTOR_CONTROL_RST;
      demod_cfg_pkg::IDX_OSC: res = demod_cfg_pkg::OSCILLATOR_PATH_CONTROL_RST;
      demod_cfg_pkg::IDX_RF:  res = demod_cfg_pkg::RF_INPUT_GAIN_CONTROL_RST;
      demod_cfg_pkg::IDX_BAL: res = demod_cfg_pkg::INPUT_TRANSFORMER_TUNING_RST;
      demod_cfg_pkg::IDX_MIX: res = demod_cfg_pkg::MIXER_LINEARITY_CONTROL_RST;
      demod_cfg_pkg::IDX_POL: res = demod_cfg_pkg::QUADRATURE_POLARITY_NULLING_RST;
      default:                res = '0;
    endcase
    return res;
  endfunction

  function automatic logic [15:0] write_mask(input logic [IDX_W-1:0] idx);
    logic [15:0] res;
    res = '0;
    case (idx)
      demod_cfg_pkg::IDX_PD:  res = demod_cfg_pkg::PHASE_DETECTOR_CONTROL_MASK;
      demod_cfg_pkg::IDX_OSC: res = demod_cfg_pkg::OSCILLATOR_PATH_CONTROL_MASK;
      demod_cfg_pkg::IDX_RF:  res = demod_cfg_pkg::RF_INPUT_GAIN_CONTROL_MASK;
      demod_cfg_pkg::IDX_BAL: res = demod_cfg_pkg::INPUT_TRANSFORMER_TUNING_MASK;
      demod_cfg_pkg::IDX_MIX: res = demod_cfg_pkg::MIXER_LINEARITY_CONTROL_MASK;
      demod_cfg_pkg::IDX_POL: res = demod_cfg_pkg::QUADRATURE_POLARITY_NULLING_MASK;
      default:                res = '0;
    endcase
    return res;
  endfunction

  logic [15:0]      regs_ff [NUM_REGS];
  logic [IDX_W:0]   dec;
  logic             hit;
  logic [IDX_W-1:0] idx;
  logic [15:0]      rdata_ff;
  logic             rvalid_ff;
  logic             addr_err_ff;
  logic             pin_meta_ff;
  logic             pin_sync_ff;
  logic             sw_sel_ff;

  assign dec = decode_addr(reg_addr_i);
  assign hit = dec[IDX_W];
  assign idx = dec[IDX_W-1:0];

  // Register storage; only masked bits take new data
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      for (int i = 0; i < NUM_REGS; i++) begin
        regs_ff[i] <= reset_value(3'(i));
      end
    end else if (reg_wr_i && hit) begin
      regs_ff[idx] <= (regs_ff[idx] & ~write_mask(idx)) | (reg_wdata_i[15:0] & write_mask(idx));
    end
  end

  // Read port: one cycle after the request; unmapped reads return zero
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rdata_ff <= '0;
      rvalid_ff <= 1'b0;
    end else begin
      rvalid_ff <= reg_rd_i;
      if (reg_rd_i) begin
        rdata_ff <= hit ? regs_ff[idx] : 16'h0000;
      end
    end
  end

  // Flags any access to an offset outside the bank, held for one cycle
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      addr_err_ff <= 1'b0;
    end else begin
      addr_err_ff <= (reg_wr_i || reg_rd_i) && !hit;
    end
  end

  assign reg_rdata_o = DATA_W'(rdata_ff);
  assign reg_rvalid_o = rvalid_ff;
  assign reg_addr_err_o = addr_err_ff;

  // Pin is asynchronous to clk_i
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pin_meta_ff <= 1'b0;
      pin_sync_ff <= 1'b0;
    end else begin
      pin_meta_ff <= switch_control_pin_i;
      pin_sync_ff <= pin_meta_ff;
    end
  end

  // Switch source mux registered so the RF path sees a glitch-free level
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sw_sel_ff <= 1'b0;
    end else if (regs_ff[demod_cfg_pkg::IDX_RF][demod_cfg_pkg::SW_SRC_BIT]) begin
      sw_sel_ff <= regs_ff[demod_cfg_pkg::IDX_RF][demod_cfg_pkg::SW_SEL_BIT];
    end else begin
      sw_sel_ff <= pin_sync_ff;
    end
  end

  // Reference path
  logic [15:0] pd_reg;
  assign pd_reg = regs_ff[demod_cfg_pkg::IDX_PD];
  assign monitor_select_o = pd_reg[demod_cfg_pkg::MON_SEL_LSB +: 3];
  assign phase_detector_sense_o = pd_reg[demod_cfg_pkg::PD_SENSE_BIT];
  assign reference_scaling_ratio_o = pd_reg[demod_cfg_pkg::REF_RATIO_LSB +: 3];

  // Ratio code 000 doubles, 001..100 divide by 2^(code-1); above 100 is undefined
  always_comb begin
    ref_multiply_o = (reference_scaling_ratio_o == demod_cfg_pkg::REF_MUL2);
    ref_ratio_invalid_o = (reference_scaling_ratio_o > demod_cfg_pkg::REF_DIV8);
    ref_divide_log2_o = 2'h0;
    if (!ref_multiply_o && !ref_ratio_invalid_o) begin
      ref_divide_log2_o = 2'(reference_scaling_ratio_o - 3'h1);
    end
  end

  // Oscillator and LO path
  logic [15:0] osc_reg;
  assign osc_reg = regs_ff[demod_cfg_pkg::IDX_OSC];
  assign ext_osc_drive_level_o = osc_reg[demod_cfg_pkg::DRV_LVL_LSB +: 2];
  assign ext_driver_halving_enable_o = osc_reg[demod_cfg_pkg::DRV_HALF_BIT];
  assign lo_eighth_divide_enable_o = osc_reg[demod_cfg_pkg::DIV8_BIT];
  assign lo_quarter_divide_enable_o = osc_reg[demod_cfg_pkg::DIV4_BIT];
  assign oscillator_core_select_o = osc_reg[demod_cfg_pkg::CORE_SEL_LSB +: 3];

  // The eighth stage sits after the quarter stage, so it sets the total when on
  always_comb begin
    if (lo_eighth_divide_enable_o) begin
      lo_divide_total_o = demod_cfg_pkg::LO_DIV_EIGHTH;
    end else if (lo_quarter_divide_enable_o) begin
      lo_divide_total_o = demod_cfg_pkg::LO_DIV_QUARTER;
    end else begin
      lo_divide_total_o = demod_cfg_pkg::LO_DIV_BASE;
    end
  end

  // Reserved core codes power no core, so a bad write cannot start two at once
  always_comb begin
    core_enable_onehot_o = 4'h0;
    external_lo_select_o = 1'b0;
    core_select_invalid_o = 1'b0;
    if (oscillator_core_select_o < demod_cfg_pkg::CORE_EXTERNAL) begin
      core_enable_onehot_o = 4'(4'h1 << oscillator_core_select_o[1:0]);
    end else if (oscillator_core_select_o == demod_cfg_pkg::CORE_EXTERNAL) begin
      external_lo_select_o = 1'b1;
    end else begin
      core_select_invalid_o = 1'b1;
    end
  end

  // RF input
  logic [15:0] rf_reg;
  logic [15:0] bal_reg;
  assign rf_reg = regs_ff[demod_cfg_pkg::IDX_RF];
  assign bal_reg = regs_ff[demod_cfg_pkg::IDX_BAL];
  assign input_switch_source_o = rf_reg[demod_cfg_pkg::SW_SRC_BIT];
  assign input_switch_select_o = sw_sel_ff;
  assign step_attenuation_setting_o = rf_reg[demod_cfg_pkg::ATTEN_LSB +: 4];
  assign transformer_output_cap_o = {1'b0, bal_reg[demod_cfg_pkg::BAL_OUT_LSB +: 3]};
  assign transformer_input_cap_o = {1'b0, bal_reg[demod_cfg_pkg::BAL_IN_LSB +: 3]};

  // Mixer
  logic [15:0] mix_reg;
  assign mix_reg = regs_ff[demod_cfg_pkg::IDX_MIX];
  assign demod_bias_code_o = mix_reg[demod_cfg_pkg::BIAS_LSB +: 3];
  assign linearizer_resistor_code_o = mix_reg[demod_cfg_pkg::RES_LSB +: 4];
  assign linearizer_capacitor_code_o = mix_reg[demod_cfg_pkg::CAP_LSB +: 4];

  // Quadrature polarity and nulling
  logic [15:0] pol_reg;
  assign pol_reg = regs_ff[demod_cfg_pkg::IDX_POL];
  assign q_polarity_switch_o = pol_reg[demod_cfg_pkg::Q_POLARITY_SWITCH_LSB +: 2];
  assign i_polarity_switch_o = pol_reg[demod_cfg_pkg::I_POLARITY_SWITCH_LSB +: 2];
  assign q_invert_o = (q_polarity_switch_o == demod_cfg_pkg::POL_INVERT_Q);
  assign i_invert_o = (i_polarity_switch_o == demod_cfg_pkg::POL_INVERT_I);

  // Codes 00 and 11 have no defined polarity; flag them for firmware
  always_comb begin
    polarity_code_invalid_o = 1'b0;
    if (q_polarity_switch_o != demod_cfg_pkg::POL_NORMAL_Q && !q_invert_o) begin
      polarity_code_invalid_o = 1'b1;
    end
    if (i_polarity_switch_o != demod_cfg_pkg::POL_NORMAL_I && !i_invert_o) begin
      polarity_code_invalid_o = 1'b1;
    end
  end

  assign q_sideband_null_o = pol_reg[demod_cfg_pkg::QNULL_LSB +: 4];
  assign i_sideband_null_o = pol_reg[demod_cfg_pkg::INULL_LSB +: 4];

endmodule // demod_config_register_bank

`default_nettype wire

/* bench/host_port_model.sv */
// Purpose: Host that issues word writes and reads into the register bank
// Assumes: One-cycle strobes launched just after a rising edge
// Notes:   Released address and data show the inverse of the last value
`timescale 1ns/1ps
`default_nettype none
module host_port_model (
  input  wire logic        clk_i,
  output logic             reg_wr_o,
  output logic             reg_rd_o,
  output logic [7:0]       reg_addr_o,
  output logic [15:0]      reg_wdata_o,
  input  wire logic [15:0] reg_rdata_i,
  input  wire logic        reg_rvalid_i
);
  initial begin
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
    reg_addr_o = 8'h00;
    reg_wdata_o = 16'h0000;
  end
  task automatic write(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_i);
    reg_wr_o <= 1'b1;
    reg_addr_o <= a;
    reg_wdata_o <= d;
    @(posedge clk_i);
    reg_wr_o <= 1'b0;
    reg_addr_o <= ~a;
    reg_wdata_o <= ~d;
    #1;
  endtask
  task automatic read(input logic [7:0] a, output logic [15:0] d, output logic v);
    @(posedge clk_i);
    reg_rd_o <= 1'b1;
    reg_addr_o <= a;
    @(posedge clk_i);
    reg_rd_o <= 1'b0;
    reg_addr_o <= ~a;
    #1;
    d = reg_rdata_i;
    v = reg_rvalid_i;
  endtask
endmodule // host_port_model
`default_nettype wire

/* bench/demod_config_register_bank_assertions.sv */
// Purpose: Port-level checker for the demodulator configuration bank
// Assumes: Single clock domain, reset active low
// Notes:   Bound to every instance of the bank
`timescale 1ns/1ps
`default_nettype none
module demod_config_register_bank_checker (
  input wire logic        clk_i,
  input wire logic        rst_b_i,
  input wire logic        reg_wr_i,
  input wire logic        reg_rd_i,
  input wire logic [7:0]  reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic        reg_rvalid_o,
  input wire logic        reg_addr_err_o,
  input wire logic        switch_control_pin_i,
  input wire logic [1:0]  ext_osc_drive_level_o,
  input wire logic        ext_driver_halving_enable_o,
  input wire logic        lo_eighth_divide_enable_o,
  input wire logic        lo_quarter_divide_enable_o,
  input wire logic [3:0]  lo_divide_total_o,
  input wire logic [2:0]  oscillator_core_select_o,
  input wire logic [3:0]  core_enable_onehot_o,
  input wire logic        input_switch_source_o,
  input wire logic        input_switch_select_o,
  input wire logic [3:0]  q_sideband_null_o,
  input wire logic [3:0]  i_sideband_null_o
);
  logic mapped;
  assign mapped = reg_addr_i inside {8'h21, 8'h22, 8'h23, 8'h30, 8'h31, 8'h32};
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  sequence s_mapped_rd;
    reg_rd_i && mapped;
  endsequence
  sequence s_pin_steady;
    (!input_switch_source_o && $stable(switch_control_pin_i))[*5];
  endsequence
  AST_RD_VALID: assert property (s_mapped_rd |=> reg_rvalid_o)
    else $error("read of a mapped register gave no valid pulse");
  AST_RVALID_CAUSE: assert property (reg_rvalid_o |-> $past(reg_rd_i))
    else $error("valid pulse without a read");
  AST_UNMAPPED: assert property ((reg_wr_i || reg_rd_i) && !mapped |=> reg_addr_err_o)
    else $error("unmapped access gave no error pulse");
  AST_OSC_WRITE: assert property (reg_wr_i && reg_addr_i == 8'h22 |=>
    {ext_osc_drive_level_o, ext_driver_halving_enable_o, lo_eighth_divide_enable_o,
     lo_quarter_divide_enable_o, oscillator_core_select_o} == $past(reg_wdata_i[7:0]))
    else $error("oscillator fields do not follow the write");
  AST_LO_DIVIDE: assert property (lo_divide_total_o == (lo_eighth_divide_enable_o ? 4'h8 :
    (lo_quarter_divide_enable_o ? 4'h4 : 4'h2)))
    else $error("lo divide total wrong");
  AST_CORE_ONEHOT: assert property (oscillator_core_select_o < 3'h4 |->
    core_enable_onehot_o == (4'h1 << oscillator_core_select_o))
    else $error("core enable does not match core select");
  AST_NULL_WRITE: assert property (reg_wr_i && reg_addr_i == 8'h32 |=>
    {q_sideband_null_o, i_sideband_null_o} == $past(reg_wdata_i[7:0]))
    else $error("sideband nulling codes do not follow the write");
  AST_SW_PIN: assert property (s_pin_steady |-> input_switch_select_o == switch_control_pin_i)
    else $error("input switch does not follow the pin");
  // Three quiet cycles: a write two edges back still reaches the registered select
  AST_SW_REG_HOLD: assert property ((input_switch_source_o && !reg_wr_i)[*3] |->
    $stable(input_switch_select_o))
    else $error("input switch moved under register control");
endmodule // demod_config_register_bank_checker
bind demod_config_register_bank demod_config_register_bank_checker u_checker (
  .clk_i(clk_i), .rst_b_i(rst_b_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
  .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_rvalid_o(reg_rvalid_o),
  .reg_addr_err_o(reg_addr_err_o), .switch_control_pin_i(switch_control_pin_i),
  .ext_osc_drive_level_o(ext_osc_drive_level_o), .ext_driver_halving_enable_o(ext_driver_halving_enable_o),
  .lo_eighth_divide_enable_o(lo_eighth_divide_enable_o), .lo_quarter_divide_enable_o(lo_quarter_divide_enable_o),
  .lo_divide_total_o(lo_divide_total_o), .oscillator_core_select_o(oscillator_core_select_o),
  .core_enable_onehot_o(core_enable_onehot_o), .input_switch_source_o(input_switch_source_o),
  .input_switch_select_o(input_switch_select_o), .q_sideband_null_o(q_sideband_null_o),
  .i_sideband_null_o(i_sideband_null_o)
);
`default_nettype wire

/* bench/tb_demod_config_register_bank.sv */
// Purpose: Self-checking bench for the demodulator configuration bank
// Assumes: Host model issues all register traffic
// Notes:   Expected values come from the register table
`timescale 1ns/1ps
`default_nettype none
module tb_demod_config_register_bank;
  localparam logic [7:0]  ADR [6] = '{8'h21, 8'h22, 8'h23, 8'h30, 8'h31, 8'h32};
  localparam logic [15:0] RST [6] = '{16'h0003, 16'h2a03, 16'h0000, 16'h0000, 16'h1101, 16'h0900};
  localparam logic [15:0] MSK [6] = '{16'h007f, 16'h00ff, 16'h0be0, 16'h00ee, 16'h1def, 16'h0fff};
  localparam logic [15:0] DIVW [4] = '{16'h0008, 16'h0010, 16'h0018, 16'h0000};
  localparam logic [15:0] DIVE [4] = '{16'h0004, 16'h0008, 16'h0008, 16'h0002};
  logic        clk_i = 1'b0;
  logic        rst_b_i = 1'b0;
  logic        pin = 1'b0;
  logic        wr, rd, rvalid, err, sw_sel, ext_lo, q_inv, i_inv, ref_mul, v;
  logic [7:0]  addr;
  logic [15:0] wdata, rdata, d;
  logic [3:0]  lo_div, atten;
  logic [2:0]  core;
  logic [2:0]  mon, bias;
  logic [1:0]  dlog;
  logic [3:0]  cout, cin, res, cap;
  logic        sense, rinv, cinv, pinv;
  int          bad_count = 0;
  int          samples_checked = 0;
  int          cycles = 0;
  always #5 clk_i = ~clk_i;
  host_port_model u_host_port_model (.clk_i(clk_i), .reg_wr_o(wr), .reg_rd_o(rd), .reg_addr_o(addr),
    .reg_wdata_o(wdata), .reg_rdata_i(rdata), .reg_rvalid_i(rvalid));
  demod_config_register_bank u_demod_config_register_bank (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .reg_wr_i(wr), .reg_rd_i(rd), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_rdata_o(rdata), .reg_rvalid_o(rvalid), .reg_addr_err_o(err),
    .switch_control_pin_i(pin), .monitor_select_o(mon), .phase_detector_sense_o(sense),
    .reference_scaling_ratio_o(), .ref_multiply_o(ref_mul), .ref_divide_log2_o(dlog), .ref_ratio_invalid_o(rinv),
    .ext_osc_drive_level_o(), .ext_driver_halving_enable_o(), .lo_eighth_divide_enable_o(),
    .lo_quarter_divide_enable_o(), .lo_divide_total_o(lo_div), .oscillator_core_select_o(core),
    .core_enable_onehot_o(), .external_lo_select_o(ext_lo), .core_select_invalid_o(cinv),
    .input_switch_source_o(), .input_switch_select_o(sw_sel), .step_attenuation_setting_o(atten),
    .transformer_output_cap_o(cout), .transformer_input_cap_o(cin), .demod_bias_code_o(bias),
    .linearizer_resistor_code_o(res), .linearizer_capacitor_code_o(cap), .q_polarity_switch_o(),
    .i_polarity_switch_o(), .q_invert_o(q_inv), .i_invert_o(i_inv), .polarity_code_invalid_o(pinv),
    .q_sideband_null_o(), .i_sideband_null_o());
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // Whole run needs well under a thousand cycles
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      bad_count++;
      end_of_test();
    end
  end
  initial begin
    repeat (2) @(posedge clk_i);
    rst_b_i <= 1'b1;
    for (int k = 0; k < 6; k++) begin
      u_host_port_model.read(ADR[k], d, v);
      check("reset value", d, RST[k]);
      check("read valid", v, 1'b1);
    end
    $display("reset test end");
    for (int k = 0; k < 6; k++) begin
      u_host_port_model.write(ADR[k], 16'hffff);
      u_host_port_model.read(ADR[k], d, v);
      check("all ones", d, RST[k] & ~MSK[k] | MSK[k]);
      u_host_port_model.write(ADR[k], 16'h0000);
      u_host_port_model.read(ADR[k], d, v);
      check("all zeros", d, RST[k] & ~MSK[k]);
    end
    $display("access test end");
    for (int c = 0; c < 16; c++) begin
      u_host_port_model.write(8'h23, 16'(c) << 5);
      check("attenuation", atten, 16'(c));
    end
    for (int c = 0; c < 5; c++) begin
      u_host_port_model.write(8'h22, 16'(c));
      check("core select", core, 16'(c));
      check("external lo", ext_lo, c == 4);
      u_host_port_model.write(8'h21, 16'(c));
      check("ref multiply", ref_mul, c == 0);
      check("ref divide", dlog, 16'(c == 0 ? 0 : c - 1));
    end
    foreach (DIVW[k]) begin
      u_host_port_model.write(8'h22, DIVW[k]);
      check("lo divide", lo_div, DIVE[k]);
    end
    for (int c = 0; c < 2; c++) begin
      u_host_port_model.write(8'h32, c[0] ? 16'h0600 : 16'h0900);
      check("q invert", q_inv, c[0]);
      check("i invert", i_inv, c[0]);
      check("polarity valid", pinv, 1'b0);
    end
    u_host_port_model.write(8'h32, 16'h0c00);
    check("q code 11", q_inv, 1'b0);
    check("polarity invalid", pinv, 1'b1);
    u_host_port_model.write(8'h21, 16'h007d);
    check("monitor select", mon, 16'h0007);
    check("detector sense", sense, 1'b1);
    check("ratio invalid", rinv, 1'b1);
    u_host_port_model.write(8'h22, 16'h0005);
    check("core invalid", cinv, 1'b1);
    u_host_port_model.write(8'h30, 16'h00a4);
    check("output cap", cout, 16'h0005);
    check("input cap", cin, 16'h0002);
    u_host_port_model.write(8'h31, 16'h0d2a);
    check("bias code", bias, 16'h0003);
    check("resistor code", res, 16'h0009);
    check("capacitor code", cap, 16'h000a);
    $display("field test end");
    u_host_port_model.write(8'h24, 16'h1234);
    u_host_port_model.read(8'h24, d, v);
    check("unmapped data", d, 16'h0000);
    check("unmapped error", err, 1'b1);
    $display("unmapped test end");
    u_host_port_model.write(8'h23, 16'h0000);
    @(posedge clk_i);
    pin <= 1'b1;
    repeat (4) @(posedge clk_i);
    #1;
    check("pin routed", sw_sel, 1'b1);
    // Select is registered, so look one edge after the write
    u_host_port_model.write(8'h23, 16'h0800);
    @(posedge clk_i);
    #1;
    check("register first input", sw_sel, 1'b0);
    u_host_port_model.write(8'h23, 16'h0a00);
    @(posedge clk_i);
    #1;
    check("register second input", sw_sel, 1'b1);
    $display("switch test end");
    end_of_test();
  end
endmodule // tb_demod_config_register_bank
`default_nettype wire
